// ==== src/bridge_window_pkg.sv ====
// Offsets, field positions, reset values and states of the window slice
package bridge_window_pkg;
  localparam logic [7:0] SEC_STATUS_OFS = 8'h1C;
  localparam logic [7:0] MEM_WIN_OFS    = 8'h20;
  localparam logic [7:0] PREF_WIN_OFS   = 8'h24;
  localparam logic [7:0] PREF_BHI_OFS   = 8'h28;
  localparam logic [7:0] PREF_LHI_OFS   = 8'h2C;
  localparam logic [7:0] IO_HI_OFS      = 8'h30;
  localparam logic [7:0] CAP_PTR_OFS    = 8'h34;
  localparam logic [7:0] OPT_ROM_OFS    = 8'h38;
  localparam logic [7:0] IRQ_LINE_OFS   = 8'h3C;
  localparam logic [7:0] ERR_MASK_OFS   = 8'h40;

  localparam int ERR_FLAG_N   = 3;
  localparam int ERR_FLAG_LSB = 29;
  localparam int BASE_LSB     = 4;
  localparam int LIMIT_LSB    = 20;
  localparam int HALF_LSB     = 16;

  localparam logic [3:0]  MEM_LOW_CODE   = 4'h0;
  localparam logic [3:0]  PREF_LOW_CODE  = 4'h1;
  localparam logic [11:0] MEM_BASE_RST   = 12'h800;
  localparam logic [11:0] MEM_LIMIT_RST  = 12'h000;
  localparam logic [11:0] PREF_BASE_RST  = 12'h800;
  localparam logic [11:0] PREF_LIMIT_RST = 12'h000;
  localparam logic [31:0] UPPER_RST      = 32'h0000_0000;
  localparam logic [15:0] IO_HI_RST      = 16'h0000;
  localparam logic [7:0]  CAP_PTR_VAL    = 8'h80;
  localparam logic [31:0] OPT_ROM_VAL    = 32'h0000_0000;
  localparam logic [7:0]  IRQ_LINE_RST   = 8'h00;
  localparam logic [2:0]  ERR_FLAG_RST   = 3'h0;
  localparam logic [2:0]  ERR_MASK_RST   = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACC  = 3'b010,
    ST_RESP = 3'b100
  } apb_state_type;
endpackage : bridge_window_pkg

// ==== src/error_flag_bank.sv ====
// Sticky error flags, set by events, cleared by writing one
`timescale 1ns/1ps
module error_flag_bank
  import bridge_window_pkg::*;
#(
  parameter int N = ERR_FLAG_N
) (
  input  wire logic         clk,     // Block clock
  input  wire logic         rst,     // Async reset, high
  input  wire logic [N-1:0] setIn,   // Event pulses
  input  wire logic [N-1:0] clrIn,   // Write-one-to-clear
  output logic      [N-1:0] flags    // Sticky flags
);
  logic [N-1:0] flags_reg;

  initial begin
    if (N < 1 || N > ERR_FLAG_N) begin
      $error("error_flag_bank: N out of range");
    end
  end

  // Set beats clear so a same-cycle event is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= N'(ERR_FLAG_RST);
    end else begin
      flags_reg <= (flags_reg & ~clrIn) | setIn;
    end
  end

  assign flags = flags_reg;
endmodule : error_flag_bank

// ==== src/bridge_window_config_regs.sv ====
// Bridge window configuration registers behind an APB slave
// Function
// - Forward: secondary master abort sets flag
// - Reverse: unsupported-request completion sets flag
// - Forward: secondary SERR seen sets flag
// - Reverse: fatal/non-fatal message sets flag
// - Forward: address or data parity sets flag
// - Reverse: poisoned TLP sets parity flag
// - Prefetch base bits 15:4, reset 800h
// - Prefetch limit bits 31:20, reset 000h
// - Prefetch low nibbles read 0001
// - Prefetch base upper 32 bits, reset zero
// - Prefetch limit upper 32 bits, reset zero
// - I/O base upper half bits 15:0
// - I/O limit upper half bits 31:16
// - Capability pointer reads 80h, rest zero
// - Interrupt line writable byte, reset zero
`timescale 1ns/1ps
module bridge_window_config_regs
  import bridge_window_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,     // 40 MHz clock
  input  wire logic              sys_rst,     // Async reset, high
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB enable
  input  wire logic              pwrite,      // APB direction
  input  wire logic [ADDR_W-1:0] paddr,       // APB byte address
  input  wire logic [31:0]       pwdata,      // APB write data
  input  wire logic [3:0]        pstrb,       // APB byte strobes
  output logic      [31:0]       prdata,      // APB read data
  output logic                   pready,      // APB ready
  output logic                   pslverr,     // APB error
  input  wire logic              fwdMode,     // High: forward bridge
  input  wire logic              secMstAbort, // Sec master abort
  input  wire logic              priUrCpl,    // UR completion in
  input  wire logic              secSerrSeen, // Sec SERR asserted
  input  wire logic              secErrMsg,   // Fatal/non-fatal msg
  input  wire logic              addrParErr,  // Address parity err
  input  wire logic              dataParErr,  // Data parity err
  input  wire logic              poisonTlp,   // Poisoned TLP seen
  output logic                   irq,         // Error interrupt
  output logic      [11:0]       memBase,     // Memory window base
  output logic      [11:0]       memLimit,    // Memory window limit
  output logic      [11:0]       prefBase,    // Prefetch base
  output logic      [11:0]       prefLimit,   // Prefetch limit
  output logic      [31:0]       prefBaseHi,  // Prefetch base 63:32
  output logic      [31:0]       prefLimitHi, // Prefetch limit 63:32
  output logic      [15:0]       ioBaseHi,    // I/O base 31:16
  output logic      [15:0]       ioLimitHi,   // I/O limit 31:16
  output logic      [7:0]        irqLine      // Interrupt line
);
  apb_state_type state_reg;
  logic [31:0]   prdata_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic          irq_reg;
  logic [11:0]   memBase_reg;
  logic [11:0]   memLimit_reg;
  logic [11:0]   prefBase_reg;
  logic [11:0]   prefLimit_reg;
  logic [31:0]   prefBaseHi_reg;
  logic [31:0]   prefLimitHi_reg;
  logic [15:0]   ioBaseHi_reg;
  logic [15:0]   ioLimitHi_reg;
  logic [7:0]    irqLine_reg;
  logic [2:0]    errMask_reg;
  logic [2:0]    errFlags;
  logic [2:0]    errSet;
  logic [2:0]    errClr;
  logic [7:0]    regAddr;
  logic          wrDone;
  logic [31:0]   memMerge;
  logic [31:0]   prefMerge;
  logic [32:0]   image;
  logic [31:0]   rdVal;
  logic          rdHit;

  initial begin
    if (ADDR_W < 7 || ADDR_W > 12) begin
      $error("bridge_window_config_regs: ADDR_W must be 7..12");
    end
  end

  // Byte-lane merge of write data into a register image
  function automatic logic [31:0] laneMerge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  st
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : laneMerge

  // Image of the dword at an offset, with hit flag in bit 32
  function automatic logic [32:0] regImage(input logic [7:0] a);
    logic [32:0] r;
    r = 33'h0_0000_0000;
    case (a)
      SEC_STATUS_OFS: r = {1'b1, errFlags, 29'h0};
      MEM_WIN_OFS:    r = {1'b1, memLimit_reg, MEM_LOW_CODE,
                           memBase_reg, MEM_LOW_CODE};
      PREF_WIN_OFS:   r = {1'b1, prefLimit_reg, PREF_LOW_CODE,
                           prefBase_reg, PREF_LOW_CODE};
      PREF_BHI_OFS:   r = {1'b1, prefBaseHi_reg};
      PREF_LHI_OFS:   r = {1'b1, prefLimitHi_reg};
      IO_HI_OFS:      r = {1'b1, ioLimitHi_reg, ioBaseHi_reg};
      CAP_PTR_OFS:    r = {1'b1, 24'h00_0000, CAP_PTR_VAL};
      OPT_ROM_OFS:    r = {1'b1, OPT_ROM_VAL};
      IRQ_LINE_OFS:   r = {1'b1, 24'h00_0000, irqLine_reg};
      ERR_MASK_OFS:   r = {1'b1, errMask_reg, 29'h0};
      default:        r = 33'h0_0000_0000;
    endcase
    return r;
  endfunction : regImage

  // Offsets above the slice alias nothing; upper bits must be zero
  localparam int ADDR_USE = (ADDR_W > 8) ? 8 : ADDR_W;
  always_comb begin
    regAddr = 8'h00;
    regAddr[ADDR_USE-1:0] = paddr[ADDR_USE-1:0];
  end

  // Process, not assign: the image reads registers beyond its argument
  always_comb image = regImage(regAddr);
  assign rdHit  = image[32] && (paddr >> 8) == '0
                  && paddr[1:0] == 2'b00;
  assign rdVal  = image[31:0];
  assign wrDone = psel && penable && pready_reg && pwrite
                  && !pslverr_reg;
  assign memMerge  = laneMerge({memLimit_reg, 4'h0, memBase_reg, 4'h0}, pwdata, pstrb);
  assign prefMerge = laneMerge({prefLimit_reg, 4'h0, prefBase_reg, 4'h0}, pwdata, pstrb);

  // APB handshake: one wait cycle, answer stands one cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= ST_IDLE;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          pready_reg <= 1'b0;
          if (psel && !penable) begin
            state_reg <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (psel && penable) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !rdHit;
            prdata_reg  <= (pwrite || !rdHit) ? 32'h0000_0000 : rdVal;
            state_reg   <= ST_RESP;
          end else if (!psel) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_RESP: begin
          pready_reg  <= 1'b0;
          pslverr_reg <= 1'b0;
          state_reg   <= ST_IDLE;
        end
        default: begin
          pready_reg <= 1'b0;
          state_reg  <= ST_IDLE;
        end
      endcase
    end
  end

  // Mode selects which detector feeds each flag
  always_comb begin
    errSet[0] = fwdMode ? secMstAbort : priUrCpl;
    errSet[1] = fwdMode ? secSerrSeen : secErrMsg;
    errSet[2] = fwdMode ? (addrParErr || dataParErr) : poisonTlp;
    errClr    = 3'h0;
    if (wrDone && regAddr == SEC_STATUS_OFS && pstrb[3]) begin
      errClr = pwdata[31:29];
    end
  end

  error_flag_bank #(
    .N (ERR_FLAG_N)
  ) u_flags (
    .clk   (ref_clk),
    .rst   (sys_rst),
    .setIn (errSet),
    .clrIn (errClr),
    .flags (errFlags)
  );

  // Window registers; only lanes with a strobe change
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memBase_reg  <= MEM_BASE_RST;
      memLimit_reg <= MEM_LIMIT_RST;
      prefBase_reg  <= PREF_BASE_RST;
      prefLimit_reg <= PREF_LIMIT_RST;
    end else if (wrDone && regAddr == MEM_WIN_OFS) begin
      memLimit_reg <= memMerge[31:20];
      memBase_reg  <= memMerge[15:4];
    end else if (wrDone && regAddr == PREF_WIN_OFS) begin
      prefLimit_reg <= prefMerge[31:20];
      prefBase_reg  <= prefMerge[15:4];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prefBaseHi_reg  <= UPPER_RST;
      prefLimitHi_reg <= UPPER_RST;
    end else if (wrDone && regAddr == PREF_BHI_OFS) begin
      prefBaseHi_reg <= laneMerge(prefBaseHi_reg, pwdata, pstrb);
    end else if (wrDone && regAddr == PREF_LHI_OFS) begin
      prefLimitHi_reg <= laneMerge(prefLimitHi_reg, pwdata, pstrb);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ioBaseHi_reg  <= IO_HI_RST;
      ioLimitHi_reg <= IO_HI_RST;
    end else if (wrDone && regAddr == IO_HI_OFS) begin
      {ioLimitHi_reg, ioBaseHi_reg} <=
        laneMerge({ioLimitHi_reg, ioBaseHi_reg}, pwdata, pstrb);
    end
  end

  // Line byte is scratch only; the bridge never decodes it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irqLine_reg <= IRQ_LINE_RST;
      errMask_reg <= ERR_MASK_RST;
    end else if (wrDone && regAddr == IRQ_LINE_OFS && pstrb[0]) begin
      irqLine_reg <= pwdata[7:0];
    end else if (wrDone && regAddr == ERR_MASK_OFS && pstrb[3]) begin
      errMask_reg <= pwdata[31:29];
    end
  end

  // Registered, so irq trails the flag by one cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(errFlags & errMask_reg);
    end
  end

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign irq         = irq_reg;
  assign memBase     = memBase_reg;
  assign memLimit    = memLimit_reg;
  assign prefBase    = prefBase_reg;
  assign prefLimit   = prefLimit_reg;
  assign prefBaseHi  = prefBaseHi_reg;
  assign prefLimitHi = prefLimitHi_reg;
  assign ioBaseHi    = ioBaseHi_reg;
  assign ioLimitHi   = ioLimitHi_reg;
  assign irqLine     = irqLine_reg;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence rdReq(logic [7:0] a);
    psel && !penable && !pwrite && regAddr == a && rdHit;
  endsequence

  sequence rdAnswer;
    psel && penable && pready_reg;
  endsequence

  sequence fullWr(logic [7:0] a);
    wrDone && regAddr == a && pstrb == 4'hF;
  endsequence

  a_ma_fwd_set: assert property (fwdMode && secMstAbort |=> errFlags[0])
    else $error("master abort flag not set");
  a_ma_rev_set: assert property (!fwdMode && priUrCpl |=> errFlags[0])
    else $error("UR completion flag not set");
  a_serr_fwd_set: assert property (
    fwdMode && secSerrSeen |=> errFlags[1])
    else $error("SERR flag not set");
  a_serr_rev_set: assert property (
    !fwdMode && secErrMsg |=> errFlags[1])
    else $error("error message flag not set");
  a_par_fwd_set: assert property (
    fwdMode && (addrParErr || dataParErr) |=> errFlags[2])
    else $error("parity flag not set");
  a_par_rev_quiet: assert property (
    !fwdMode && !poisonTlp && !errFlags[2] && errClr == 3'h0
    |=> !errFlags[2])
    else $error("parity flag set without poisoned TLP");
  a_par_rev_set: assert property (
    !fwdMode && poisonTlp |=> errFlags[2])
    else $error("poisoned TLP flag not set");
  a_flag_w1c: assert property (
    errClr[0] && !errSet[0] |=> !errFlags[0])
    else $error("flag not cleared by write one");
  a_pref_base_wr: assert property (
    fullWr(PREF_WIN_OFS) |=> prefBase_reg == $past(pwdata[15:4])
    && prefLimit_reg == $past(pwdata[31:20]))
    else $error("prefetch window write lost");
  a_pref_nibble: assert property (
    rdReq(PREF_WIN_OFS) ##2 rdAnswer
    |-> prdata[3:0] == PREF_LOW_CODE && prdata[19:16] == PREF_LOW_CODE)
    else $error("prefetch nibble not 0001");
  a_cap_ptr_val: assert property (
    rdReq(CAP_PTR_OFS) ##2 rdAnswer |-> prdata == 32'h0000_0080)
    else $error("capability pointer wrong");
  a_rom_zero: assert property (
    rdReq(OPT_ROM_OFS) ##2 rdAnswer |-> prdata == 32'h0000_0000)
    else $error("option ROM not zero");
  a_upper_wr: assert property (
    fullWr(PREF_BHI_OFS) |=> prefBaseHi_reg == $past(pwdata))
    else $error("prefetch upper base write lost");
  a_upper_lim_wr: assert property (
    fullWr(PREF_LHI_OFS) |=> prefLimitHi_reg == $past(pwdata))
    else $error("prefetch upper limit write lost");
  a_io_hi_wr: assert property (
    fullWr(IO_HI_OFS) |=> {ioLimitHi_reg, ioBaseHi_reg} == $past(pwdata))
    else $error("I/O upper halves write lost");
  a_irq_line_wr: assert property (
    wrDone && regAddr == IRQ_LINE_OFS && pstrb[0]
    |=> irqLine_reg == $past(pwdata[7:0]))
    else $error("interrupt line write lost");
  a_irq_follow: assert property (
    |(errFlags & errMask_reg) |=> irq)
    else $error("irq not raised");
endmodule : bridge_window_config_regs

// ==== verification/error_event_source.sv ====
// Model of the bridge interface logic that raises error events
`timescale 1ns/1ps
module error_event_source (
  input  wire logic clk,         // Block clock
  output logic      secMstAbort, // Sec master abort
  output logic      priUrCpl,    // UR completion in
  output logic      secSerrSeen, // Sec SERR asserted
  output logic      secErrMsg,   // Fatal/non-fatal msg
  output logic      addrParErr,  // Address parity err
  output logic      dataParErr,  // Data parity err
  output logic      poisonTlp    // Poisoned TLP seen
);
  logic [6:0] evVec = 7'h00;
  assign {poisonTlp, dataParErr, addrParErr, secErrMsg, secSerrSeen, priUrCpl,
          secMstAbort} = evVec;

  // One-cycle event; idle level is inactive low
  task automatic pulse(input int idx);
    @(posedge clk);
    evVec[idx] <= 1'b1;
    @(posedge clk);
    evVec[idx] <= 1'b0;
  endtask : pulse
endmodule : error_event_source

// ==== verification/tb_bridge_window_config_regs.sv ====
// Self-checking bench for the bridge window configuration registers
`timescale 1ns/1ps
module tb_bridge_window_config_regs;
  import bridge_window_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fwdMode = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, shadow [0:9];
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, err;
  logic        secMstAbort, priUrCpl, secSerrSeen, secErrMsg, addrParErr, dataParErr, poisonTlp;
  logic [31:0] expFlags = 32'h0;
  logic [11:0] memBase, memLimit, prefBase, prefLimit;
  logic [31:0] prefBaseHi, prefLimitHi;
  logic [15:0] ioBaseHi, ioLimitHi;
  logic [7:0]  irqLine;
  int          error_cnt = 0, samples_checked = 0, seed = 20297;

  bridge_window_config_regs i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fwdMode(fwdMode),
    .secMstAbort(secMstAbort), .priUrCpl(priUrCpl), .secSerrSeen(secSerrSeen),
    .secErrMsg(secErrMsg), .addrParErr(addrParErr), .dataParErr(dataParErr),
    .poisonTlp(poisonTlp), .irq(irq), .memBase(memBase), .memLimit(memLimit),
    .prefBase(prefBase), .prefLimit(prefLimit), .prefBaseHi(prefBaseHi),
    .prefLimitHi(prefLimitHi), .ioBaseHi(ioBaseHi), .ioLimitHi(ioLimitHi),
    .irqLine(irqLine));

  error_event_source i_src (.clk(ref_clk), .secMstAbort(secMstAbort), .priUrCpl(priUrCpl),
    .secSerrSeen(secSerrSeen), .secErrMsg(secErrMsg), .addrParErr(addrParErr),
    .dataParErr(dataParErr), .poisonTlp(poisonTlp));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Holds the request until pready is seen high; bounded wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a >= SEC_STATUS_OFS && a <= ERR_MASK_OFS && a[1:0] == 2'b00) begin
      shadow[(a - SEC_STATUS_OFS) >> 2] = d;
      if (a == SEC_STATUS_OFS)
        expFlags &= ~d;
    end
  endtask : apb

  function automatic logic [31:0] exp_read(input int i);
    case (i)
      0: exp_read = expFlags;
      1: exp_read = shadow[1] & 32'hFFF0FFF0;
      2: exp_read = (shadow[2] & 32'hFFF0FFF0) | 32'h00010001;
      6: exp_read = {24'h000000, CAP_PTR_VAL};
      7: exp_read = OPT_ROM_VAL;
      8: exp_read = shadow[8] & 32'h000000FF;
      9: exp_read = shadow[9] & 32'hE0000000;
      default: exp_read = shadow[i];
    endcase
  endfunction : exp_read

  task automatic init_shadow;
    foreach (shadow[i]) shadow[i] = 32'h0;
    shadow[1] = {16'h0000, MEM_BASE_RST, 4'h0};
    shadow[2] = {16'h0000, PREF_BASE_RST, 4'h0};
    expFlags = 32'h0;
  endtask : init_shadow

  // Flag bit expected for event index in the given mode
  function automatic logic [31:0] ev_bit(input int idx, input logic fwd);
    int b;
    b = fwd ? ((idx == 0) ? 29 : (idx == 2) ? 30 : (idx == 4 || idx == 5) ? 31 : 0)
            : ((idx == 1) ? 29 : (idx == 3) ? 30 : (idx == 6) ? 31 : 0);
    ev_bit = (b == 0) ? 32'h0 : (32'h1 << b);
  endfunction : ev_bit

  task automatic check_all;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, SEC_STATUS_OFS + 8'(4 * i), 32'h0);
      chk(rd, exp_read(i));
      chk({31'h0, err}, 32'h0);
    end
    chk({memLimit, 4'h0, memBase, 4'h0}, exp_read(1));
    chk({prefLimit, 4'h0, prefBase, 4'h0}, shadow[2] & 32'hFFF0FFF0);
    chk(prefBaseHi, exp_read(3));
    chk(prefLimitHi, exp_read(4));
    chk({ioLimitHi, ioBaseHi}, exp_read(5));
    chk({24'h0, irqLine}, exp_read(8));
  endtask : check_all

  initial begin
    #(25 * 20000);
    error_cnt++;
    close_out();
  end

  initial begin
    init_shadow();
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    check_all();
    $display("test reset_values done");
    repeat (3) begin
      for (int i = 0; i < 10; i++)
        apb(1'b1, SEC_STATUS_OFS + 8'(4 * i), $random(seed));
      check_all();
    end
    $display("test random_rw done");
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    init_shadow();
    check_all();
    $display("test mid_reset done");
    apb(1'b0, 8'h44, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'b1, 8'h21, 32'hFFFFFFFF);
    chk({rd[31:1], err}, 32'h1);
    $display("test unmapped done");
    apb(1'b1, ERR_MASK_OFS, 32'hE0000000);
    for (int m = 0; m < 2; m++) begin
      fwdMode <= (m == 0);
      for (int e = 0; e < 7; e++) begin
        i_src.pulse(e);
        expFlags = ev_bit(e, m == 0);
        repeat (2) @(posedge ref_clk);
        chk({31'h0, irq}, {31'h0, expFlags != 0});
        apb(1'b1, SEC_STATUS_OFS, 32'h0);
        apb(1'b0, SEC_STATUS_OFS, 32'h0);
        chk(rd, expFlags);
        apb(1'b1, SEC_STATUS_OFS, 32'hFFFFFFFF);
        apb(1'b0, SEC_STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
      end
    end
    $display("test error_events done");
    close_out();
  end
endmodule : tb_bridge_window_config_regs
